// ---- logic/serial_port_pkg.sv ----
package serial_port_pkg;

    // ****************************************************************
    // register map and field layout
    // ****************************************************************
    localparam logic SEL_CONTROL = 1'b0;
    localparam logic SEL_DATA = 1'b1;
    localparam int MODE_BIT = 7;
    localparam int FIXED_ONE_BIT = 6;
    localparam int ADDR_FILT_BIT = 5;
    localparam int RX_EN_BIT = 4;
    localparam int TX_NINTH_BIT = 3;
    localparam int RX_NINTH_BIT = 2;
    localparam int TX_DONE_BIT = 1;
    localparam int RX_DONE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ****************************************************************
    // frame and buffer sizes
    // ****************************************************************
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;
    localparam int TX_FIFO_DEPTH = 16;
    localparam int TX_WORD_WIDTH = 9;

    // ****************************************************************
    // states and carriers
    // ****************************************************************
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SHIFT = 3'b010,
        TX_STOP = 3'b100
    } tx_state_e;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic sel;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic run;
        logic tick;
        logic [7:0] reload;
        logic tx_ovf;
    } baud_in_s;

    typedef struct packed {
        logic [7:0] count;
        logic overflow;
    } timer_state_s;

endpackage

// ---- logic/sync_fifo.sv ----
module sync_fifo
    import serial_port_pkg::*;
#(
    parameter int WIDTH = TX_WORD_WIDTH,
    parameter int DEPTH = TX_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } fifo_state_s;

    fifo_state_s s_reg;
    fifo_state_s s_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (s_reg.wr_ptr[AW] != s_reg.rd_ptr[AW])
        && (s_reg.wr_ptr[AW-1:0] == s_reg.rd_ptr[AW-1:0]);
    assign empty = s_reg.wr_ptr == s_reg.rd_ptr;
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign push = in_valid_i & ~full;
    assign pop = out_ready_i & ~empty;
    assign out_data_o = mem[s_reg.rd_ptr[AW-1:0]];

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[s_reg.wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    full_refuses_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        full |-> !in_ready_o ##1 $stable(s_reg.wr_ptr))
        else $error("fifo accepted a word while full");
endmodule

// ---- logic/rx_baud_timer.sv ----
module rx_baud_timer
    import serial_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic [7:0] reload_i,
    input wire logic force_reload_i,
    output logic overflow_o
);
    timer_state_s s_reg;
    timer_state_s s_next;

    // private copy of the tx timer; a start edge restarts it
    always_comb begin
        s_next = s_reg;
        s_next.overflow = 1'b0;
        if (force_reload_i) begin
            s_next.count = reload_i;
        end else if (run_i && tick_i) begin
            if (s_reg.count == 8'hFF) begin
                s_next.count = reload_i;
                s_next.overflow = 1'b1;
            end else begin
                s_next.count = s_reg.count + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign overflow_o = s_reg.overflow;

    forced_reload_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        force_reload_i |=> s_reg.count == $past(reload_i) && !overflow_o)
        else $error("start edge did not reload the rx timer");

    wrap_reload_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        run_i && tick_i && s_reg.count == 8'hFF && !force_reload_i
            |=> overflow_o && s_reg.count == $past(reload_i))
        else $error("rx timer did not reload on overflow");
endmodule

// ---- logic/async_serial_port.sv ----
// Summary of operation
// - independent full duplex transmit and receive paths
// - receive latch separate from receive shifter
// - data buffer: read rx latch, write tx
// - interrupt when enabled and any flag set
// - flags cleared only by software write
// - tx bit clock from external timer overflow
// - both timer overflow streams divided by two
// - private rx timer reloads from same value
// - start edge forces rx timer reload
// - bit rate is timer rate over two
// - control bit 7 selects frame length
// - 8-bit frame: start, eight lsb-first, stop
// - 8-bit accept: data and stop bit stored
// - data write starts tx; done at stop
// - receiver takes frames only when enabled
// - 8-bit accept needs done clear, filtered stop
// - overrun keeps first byte, drops later
// - 9-bit frame adds ninth bit from control
// - 9-bit accept stores ninth, ignores stop
// - 9-bit accept needs done clear, filtered ninth
// - select zero 8-bit, one 9-bit frames
// - rx done set when stop bit sampled
module async_serial_port
    import serial_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input sfr_req_s sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    input baud_in_s baud_i,
    input wire logic irq_enable_i,
    output logic irq_o,
    output logic tx_ready_o,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic mode;
        logic addr_filt;
        logic rx_en;
        logic tx_ninth;
        logic rx_ninth;
        logic tx_done;
        logic rx_done;
        logic [7:0] rx_latch;
        logic [7:0] rdata;
        tx_state_e tx_state;
        logic [8:0] tx_shift;
        logic [3:0] tx_cnt;
        logic tx_div;
        logic txd;
        logic rx_sync1;
        logic rx_sync2;
        logic rx_prev;
        rx_state_e rx_state;
        logic [8:0] rx_shift;
        logic [3:0] rx_cnt;
        logic rx_phase;
    } port_state_s;

    port_state_s s_reg;
    port_state_s s_next;

    logic ctrl_wr;
    logic data_wr;
    logic data_rd;
    logic ctrl_rd;
    logic [3:0] nbits;
    logic tx_tick;
    logic rx_ovf;
    logic samp;
    logic start_det;
    logic rx_bit;
    logic [7:0] rx_data;
    logic rx_ninth_now;
    logic rx_accept;
    logic tx_done_set;
    logic tx_free;
    logic fifo_valid;
    logic fifo_pop;
    logic [TX_WORD_WIDTH-1:0] fifo_word;
    logic [7:0] ctrl_byte;

    function automatic logic sel_hit(input sfr_req_s req, input logic sel);
        sel_hit = req.sel == sel;
    endfunction

    // ****************************************************************
    // register access
    // ****************************************************************
    assign ctrl_wr = sfr_req_i.wr && sel_hit(sfr_req_i, SEL_CONTROL);
    assign data_wr = sfr_req_i.wr && sel_hit(sfr_req_i, SEL_DATA);
    assign ctrl_rd = sfr_req_i.rd && sel_hit(sfr_req_i, SEL_CONTROL);
    assign data_rd = sfr_req_i.rd && sel_hit(sfr_req_i, SEL_DATA);
    assign ctrl_byte = {s_reg.mode, CTRL_RESET[FIXED_ONE_BIT],
        s_reg.addr_filt, s_reg.rx_en, s_reg.tx_ninth, s_reg.rx_ninth,
        s_reg.tx_done, s_reg.rx_done};

    // ****************************************************************
    // bit clocks
    // ****************************************************************
    assign nbits = s_reg.mode ? DATA_BITS_9 : DATA_BITS_8;
    assign tx_tick = baud_i.tx_ovf & s_reg.tx_div;
    assign samp = rx_ovf & ~s_reg.rx_phase;
    assign rx_bit = s_reg.rx_sync2;
    assign start_det = (s_reg.rx_state == RX_IDLE) && s_reg.rx_en
        && s_reg.rx_prev && !rx_bit;

    rx_baud_timer rx_baud_timer_inst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .run_i(baud_i.run),
        .tick_i(baud_i.tick),
        .reload_i(baud_i.reload),
        .force_reload_i(start_det),
        .overflow_o(rx_ovf)
    );

    // ****************************************************************
    // transmit buffer
    // ****************************************************************
    assign tx_free = (s_reg.tx_state == TX_IDLE)
        || (s_reg.tx_state == TX_STOP);
    assign fifo_pop = tx_tick && tx_free;

    sync_fifo #(
        .WIDTH(TX_WORD_WIDTH),
        .DEPTH(TX_FIFO_DEPTH)
    ) sync_fifo_inst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(data_wr),
        .in_ready_o(tx_ready_o),
        .in_data_i({s_reg.tx_ninth, sfr_req_i.wdata}),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_word)
    );

    // ****************************************************************
    // receive decisions
    // ****************************************************************
    assign rx_data = s_reg.mode ? s_reg.rx_shift[7:0]
        : s_reg.rx_shift[8:1];
    // in 8-bit frames the stop bit takes the ninth bit's place
    assign rx_ninth_now = s_reg.mode ? s_reg.rx_shift[8] : rx_bit;
    assign rx_accept = (s_reg.rx_state == RX_STOP) && samp
        && !s_reg.rx_done
        && (!s_reg.addr_filt || rx_ninth_now);
    assign tx_done_set = (s_reg.tx_state == TX_SHIFT) && tx_tick
        && (s_reg.tx_cnt == nbits);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        // control register; hardware set beats software clear
        if (ctrl_wr) begin
            s_next.mode = sfr_req_i.wdata[MODE_BIT];
            s_next.addr_filt = sfr_req_i.wdata[ADDR_FILT_BIT];
            s_next.rx_en = sfr_req_i.wdata[RX_EN_BIT];
            s_next.tx_ninth = sfr_req_i.wdata[TX_NINTH_BIT];
            s_next.rx_ninth = sfr_req_i.wdata[RX_NINTH_BIT];
            s_next.tx_done = sfr_req_i.wdata[TX_DONE_BIT];
            s_next.rx_done = sfr_req_i.wdata[RX_DONE_BIT];
        end
        if (ctrl_rd) begin
            s_next.rdata = ctrl_byte;
        end else if (data_rd) begin
            s_next.rdata = s_reg.rx_latch;
        end

        // transmitter
        if (baud_i.tx_ovf) begin
            s_next.tx_div = ~s_reg.tx_div;
        end
        if (tx_tick) begin
            case (s_reg.tx_state)
                TX_IDLE, TX_STOP: begin
                    if (fifo_valid) begin
                        s_next.tx_shift = fifo_word;
                        s_next.tx_cnt = 4'h0;
                        s_next.txd = 1'b0;
                        s_next.tx_state = TX_SHIFT;
                    end else begin
                        s_next.txd = 1'b1;
                        s_next.tx_state = TX_IDLE;
                    end
                end
                TX_SHIFT: begin
                    if (s_reg.tx_cnt == nbits) begin
                        s_next.txd = 1'b1;
                        s_next.tx_done = 1'b1;
                        s_next.tx_state = TX_STOP;
                    end else begin
                        s_next.txd = s_reg.tx_shift[0];
                        s_next.tx_shift = {1'b0, s_reg.tx_shift[8:1]};
                        s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
                    end
                end
                default: begin
                    s_next.tx_state = TX_IDLE;
                end
            endcase
        end

        // receiver input synchroniser
        s_next.rx_sync1 = serial_in_pin_i;
        s_next.rx_sync2 = s_reg.rx_sync1;
        s_next.rx_prev = s_reg.rx_sync2;

        // receiver
        if (rx_ovf) begin
            s_next.rx_phase = ~s_reg.rx_phase;
        end
        case (s_reg.rx_state)
            RX_IDLE: begin
                if (start_det) begin
                    s_next.rx_phase = 1'b0;
                    s_next.rx_cnt = 4'h0;
                    s_next.rx_state = RX_START;
                end
            end
            RX_START: begin
                if (samp) begin
                    s_next.rx_state = rx_bit ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (samp) begin
                    s_next.rx_shift = {rx_bit, s_reg.rx_shift[8:1]};
                    s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
                    if (s_reg.rx_cnt == nbits - 4'h1) begin
                        s_next.rx_state = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (samp) begin
                    s_next.rx_state = RX_IDLE;
                end
            end
            default: begin
                s_next.rx_state = RX_IDLE;
            end
        endcase
        if (rx_accept) begin
            s_next.rx_latch = rx_data;
            s_next.rx_ninth = rx_ninth_now;
            s_next.rx_done = 1'b1;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg.mode <= CTRL_RESET[MODE_BIT];
            s_reg.addr_filt <= CTRL_RESET[ADDR_FILT_BIT];
            s_reg.rx_en <= CTRL_RESET[RX_EN_BIT];
            s_reg.tx_ninth <= CTRL_RESET[TX_NINTH_BIT];
            s_reg.rx_ninth <= CTRL_RESET[RX_NINTH_BIT];
            s_reg.tx_done <= CTRL_RESET[TX_DONE_BIT];
            s_reg.rx_done <= CTRL_RESET[RX_DONE_BIT];
            s_reg.rx_latch <= DATA_RESET;
            s_reg.rdata <= DATA_RESET;
            s_reg.tx_state <= TX_IDLE;
            s_reg.tx_shift <= 9'h000;
            s_reg.tx_cnt <= 4'h0;
            s_reg.tx_div <= 1'b0;
            s_reg.txd <= 1'b1;
            s_reg.rx_sync1 <= 1'b1;
            s_reg.rx_sync2 <= 1'b1;
            s_reg.rx_prev <= 1'b1;
            s_reg.rx_state <= RX_IDLE;
            s_reg.rx_shift <= 9'h000;
            s_reg.rx_cnt <= 4'h0;
            s_reg.rx_phase <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign sfr_rdata_o = s_reg.rdata;
    assign serial_out_pin_o = s_reg.txd;
    assign irq_o = irq_enable_i && (s_reg.tx_done || s_reg.rx_done);

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    irq_follows_flags_a: assert property (
        (tx_done_set || rx_accept) ##1 irq_enable_i |-> irq_o)
        else $error("interrupt missing while a flag is set");

    flags_held_a: assert property (
        s_reg.rx_done && !ctrl_wr |=> s_reg.rx_done)
        else $error("rx done flag dropped without a write");

    tx_done_at_stop_a: assert property (
        tx_done_set |=> s_reg.tx_done && serial_out_pin_o
            && s_reg.tx_state == TX_STOP)
        else $error("tx done not set at stop bit start");

    start_bit_low_a: assert property (
        fifo_pop && fifo_valid |=> !serial_out_pin_o
            && s_reg.tx_state == TX_SHIFT)
        else $error("start bit not driven low");

    idle_line_high_a: assert property (
        s_reg.tx_state == TX_IDLE |-> serial_out_pin_o)
        else $error("line not idle high");

    rx_disabled_quiet_a: assert property (
        !s_reg.rx_en && s_reg.rx_state == RX_IDLE
            |=> s_reg.rx_state == RX_IDLE)
        else $error("receiver started while disabled");

    overrun_keeps_a: assert property (
        s_reg.rx_done && !ctrl_wr |=> $stable(s_reg.rx_latch)
            && $stable(s_reg.rx_ninth))
        else $error("receive latch overwritten on overrun");

    accept_loads_a: assert property (
        rx_accept |=> s_reg.rx_done && s_reg.rx_latch == $past(rx_data)
            && s_reg.rx_ninth == $past(rx_ninth_now))
        else $error("accepted frame not loaded");

    filter_rejects_a: assert property (
        s_reg.rx_state == RX_STOP && samp && !s_reg.rx_done
            && s_reg.addr_filt && !rx_ninth_now && !ctrl_wr
            |=> !s_reg.rx_done)
        else $error("filtered frame set rx done");

    half_rate_a: assert property (
        tx_tick |-> ##1 !tx_tick)
        else $error("tx bit tick on consecutive cycles");
endmodule

// ---- dv/remote_uart.sv ----
module remote_uart #(
    parameter int BIT_CYCLES = 32
) (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic nine_mode_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] rx_q[$];
    logic [9:0] rx_f;

    initial line_o = 1'b1;

    // ****************************************************************
    // frame sender and false start
    // ****************************************************************
    task automatic send(input logic [7:0] d, input logic ninth,
        input logic stop);
        @(posedge clk_i);
        line_o <= 1'b0;
        repeat (BIT_CYCLES) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            line_o <= d[i];
            repeat (BIT_CYCLES) @(posedge clk_i);
        end
        if (nine_mode_i) begin
            line_o <= ninth;
            repeat (BIT_CYCLES) @(posedge clk_i);
        end
        line_o <= stop;
        repeat (BIT_CYCLES) @(posedge clk_i);
        line_o <= 1'b1;
    endtask

    task automatic glitch();
        @(posedge clk_i);
        line_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        line_o <= 1'b1;
    endtask

    // ****************************************************************
    // receiver: {stop, ninth, data}, ninth reads 1 in 8-bit frames
    // ****************************************************************
    always begin
        @(negedge line_i);
        repeat (BIT_CYCLES / 2) @(posedge clk_i);
        if (line_i === 1'b0) begin
            rx_f = 10'h3FF;
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge clk_i);
                rx_f[i] = line_i;
            end
            if (nine_mode_i) begin
                repeat (BIT_CYCLES) @(posedge clk_i);
                rx_f[8] = line_i;
            end
            repeat (BIT_CYCLES) @(posedge clk_i);
            rx_f[9] = line_i;
            rx_q.push_back(rx_f);
        end
    end
endmodule

// ---- dv/async_serial_port_tb.sv ----
`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); \
    end \
end

module async_serial_port_tb
    import serial_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] RELOAD = 8'hF0;
    localparam int BIT_CYCLES = 2 * (256 - int'(RELOAD));

    logic clk_i;
    logic resetn_i;
    sfr_req_s sfr_req;
    logic [7:0] sfr_rdata;
    baud_in_s baud;
    logic irq_enable;
    logic irq;
    logic tx_ready;
    logic ser_in;
    logic ser_out;
    logic nine_mode;
    logic [7:0] tl_reg;
    logic ovf_reg;
    logic took;
    logic [7:0] exp_q[$];
    int err_count;
    int tests_run;

    // ****************************************************************
    // clock, baud timer and instances
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tl_reg <= RELOAD;
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= (tl_reg == 8'hFF);
            tl_reg <= (tl_reg == 8'hFF) ? RELOAD : tl_reg + 8'h01;
        end
    end

    assign baud = '{run: 1'b1, tick: 1'b1, reload: RELOAD, tx_ovf: ovf_reg};

    async_serial_port async_serial_port_inst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .sfr_req_i(sfr_req),
        .sfr_rdata_o(sfr_rdata),
        .baud_i(baud),
        .irq_enable_i(irq_enable),
        .irq_o(irq),
        .tx_ready_o(tx_ready),
        .serial_in_pin_i(ser_in),
        .serial_out_pin_o(ser_out)
    );

    remote_uart #(.BIT_CYCLES(BIT_CYCLES)) remote_uart_inst (
        .clk_i(clk_i),
        .line_i(ser_out),
        .nine_mode_i(nine_mode),
        .line_o(ser_in)
    );

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic conclude();
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic sel, input logic [7:0] d);
        @(posedge clk_i);
        sfr_req <= '{wr: 1'b1, rd: 1'b0, sel: sel, wdata: d};
        #1 took = tx_ready;
        @(posedge clk_i);
        sfr_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic sel, output logic [7:0] d);
        @(posedge clk_i);
        sfr_req.rd <= 1'b1;
        sfr_req.sel <= sel;
        @(posedge clk_i);
        sfr_req.rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask

    task automatic rd_chk(input logic sel, input logic [7:0] e);
        logic [7:0] d;
        rd(sel, d);
        `CHK(d, e)
    endtask

    task automatic wait_ctrl(input logic [7:0] m);
        logic [7:0] c;
        c = 8'h00;
        for (int n = 0; n < 3000 && (c & m) !== m; n++) begin
            rd(SEL_CONTROL, c);
        end
        if ((c & m) !== m) begin
            err_count++;
            conclude();
        end
    endtask

    task automatic wait_rx(input int k);
        for (int n = 0; n < 20000 && remote_uart_inst.rx_q.size() < k; n++)
            @(posedge clk_i);
        if (remote_uart_inst.rx_q.size() < k) begin
            err_count++;
            conclude();
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        resetn_i = 1'b0;
        sfr_req = '0;
        irq_enable = 1'b0;
        nine_mode = 1'b0;
        took = 1'b0;
        err_count = 0;
        tests_run = 0;
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1 `CHK(ser_out, 1'b1)
        `CHK(tx_ready, 1'b1)
        `CHK(irq, 1'b0)
        rd_chk(SEL_CONTROL, CTRL_RESET);
        rd_chk(SEL_DATA, DATA_RESET);
        wr(SEL_CONTROL, 8'h00);
        rd_chk(SEL_CONTROL, 8'h40);
        // transmit and receive at once, last data bit low
        wr(SEL_CONTROL, 8'h10);
        irq_enable <= 1'b1;
        wr(SEL_DATA, 8'h25);
        fork
            remote_uart_inst.send(8'h5A, 1'b0, 1'b1);
        join_none
        wait_ctrl(8'h02);
        `CHK(ser_out, 1'b1)
        `CHK(irq, 1'b1)
        wait_rx(1);
        `CHK(remote_uart_inst.rx_q[0], 10'h325)
        wait_ctrl(8'h01);
        rd_chk(SEL_DATA, 8'h5A);
        rd_chk(SEL_CONTROL, 8'h57);
        // overrun keeps first byte; forked frame must end first
        repeat (32) @(posedge clk_i);
        remote_uart_inst.send(8'h77, 1'b0, 1'b1);
        repeat (64) @(posedge clk_i);
        rd_chk(SEL_DATA, 8'h5A);
        `CHK(irq, 1'b1)
        wr(SEL_CONTROL, 8'h10);
        #1 `CHK(irq, 1'b0)
        irq_enable <= 1'b0;
        // receiver disabled
        wr(SEL_CONTROL, 8'h00);
        remote_uart_inst.send(8'h11, 1'b0, 1'b1);
        repeat (64) @(posedge clk_i);
        rd_chk(SEL_CONTROL, 8'h40);
        // stop bit filter
        wr(SEL_CONTROL, 8'h30);
        remote_uart_inst.send(8'h33, 1'b0, 1'b0);
        repeat (64) @(posedge clk_i);
        rd_chk(SEL_CONTROL, 8'h70);
        remote_uart_inst.send(8'h33, 1'b0, 1'b1);
        repeat (64) @(posedge clk_i);
        rd_chk(SEL_CONTROL, 8'h75);
        // false start then a real frame
        wr(SEL_CONTROL, 8'h10);
        remote_uart_inst.glitch();
        repeat (200) @(posedge clk_i);
        rd_chk(SEL_CONTROL, 8'h50);
        remote_uart_inst.send(8'hC3, 1'b0, 1'b1);
        repeat (64) @(posedge clk_i);
        rd_chk(SEL_DATA, 8'hC3);
        // 9-bit frames, address filter
        nine_mode <= 1'b1;
        wr(SEL_CONTROL, 8'hB0);
        remote_uart_inst.send(8'h44, 1'b0, 1'b1);
        repeat (64) @(posedge clk_i);
        rd_chk(SEL_CONTROL, 8'hF0);
        remote_uart_inst.send(8'h81, 1'b1, 1'b1);
        repeat (64) @(posedge clk_i);
        rd_chk(SEL_CONTROL, 8'hF5);
        rd_chk(SEL_DATA, 8'h81);
        wr(SEL_CONTROL, 8'h90);
        remote_uart_inst.send(8'h6E, 1'b0, 1'b0);
        repeat (64) @(posedge clk_i);
        rd_chk(SEL_CONTROL, 8'hD1);
        rd_chk(SEL_DATA, 8'h6E);
        // 9-bit transmit with ninth bit set
        remote_uart_inst.rx_q.delete();
        wr(SEL_CONTROL, 8'h98);
        wr(SEL_DATA, 8'h96);
        wait_rx(1);
        `CHK(remote_uart_inst.rx_q[0], 10'h396)
        wait_ctrl(8'h02);
        // fill the transmit buffer past full, then drain
        nine_mode <= 1'b0;
        wr(SEL_CONTROL, 8'h00);
        remote_uart_inst.rx_q.delete();
        for (int i = 0; i < 20; i++) begin
            wr(SEL_DATA, 8'h30 + 8'(i));
            if (took === 1'b1)
                exp_q.push_back(8'h30 + 8'(i));
        end
        `CHK(tx_ready, 1'b0)
        wait_rx(exp_q.size());
        repeat (800) @(posedge clk_i);
        `CHK(remote_uart_inst.rx_q.size(), exp_q.size())
        for (int i = 0; i < exp_q.size(); i++)
            `CHK(remote_uart_inst.rx_q[i], {2'b11, exp_q[i]})
        `CHK(exp_q.size() >= TX_FIFO_DEPTH, 1'b1)
        conclude();
    end
endmodule
